// file: pem_map.svh
// Constants for the port E pin function selector
`ifndef PEM_MAP_SVH
`define PEM_MAP_SVH
`define PEM_NUM_GEN_PINS 3
`define PEM_DIR_OUT 1'h0
`define PEM_DIR_IN 1'h1
`define PEM_DIR_RESET 3'h7
`define PEM_ANA_RESET 3'h7
`define PEM_PIN0 0
`define PEM_PIN1 1
`define PEM_PIN2 2
`define PEM_PIN3 3
`define PEM_SYNC_RESET 4'hF
`define PEM_DRIVE_RESET 3'h0
`define PEM_INPUT_RESET 4'h0
`define PEM_CAP_RESET 1'h0
`define PEM_CLEAR_RESET 1'h1
`endif

// file: pem_pkg.sv
// Types for the port E pin function selector
package pem_pkg;
	// Per-pin function as seen by the selector
	typedef enum logic [2:0] {
		PEM_FN_LATCH = 3'h0,
		PEM_FN_PERIPH = 3'h1,
		PEM_FN_DIG_IN = 3'h2,
		PEM_FN_ANALOG = 3'h3,
		PEM_FN_OFF = 3'h4
	} pem_fn_t;
	// Peripheral outputs that may claim a pin
	typedef struct packed {
		logic unit3_pwm_a;
		logic unit3_pwm_a_en;
		logic unit3_pwm_b;
		logic unit3_pwm_b_en;
		logic unit3_cmp;
		logic unit3_cmp_en;
		logic unit5_cmp;
		logic unit5_cmp_en;
	} pem_periph_t;
	// Per-pin configuration
	typedef struct packed {
		logic [2:0] direction_control;
		logic [2:0] analog_select;
	} pem_cfg_t;
endpackage : pem_pkg

// file: pem_pin_mux.sv
// Port E pin function selector: pins 0..2 general, pin 3 input or master clear
`timescale 1ns/10ps
`include "pem_map.svh"

module pem_pin_mux
	import pem_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire pem_cfg_t cfg,
	input wire logic [2:0] output_latch,
	input wire pem_periph_t periph,
	input wire logic unit3_pin_route_select,
	input wire logic external_reset_enable,
	input wire logic [3:0] pin_in,
	output logic [2:0] pin_out,
	output logic [2:0] pin_oe,
	output logic [3:0] pin_input_value,
	output logic [2:0] analog_en,
	output logic unit3_capture_in,
	output logic unit5_capture_in,
	output logic master_clear_n
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [3:0] sync3_q;
	logic [3:0] stable_q;
	logic [2:0] dir_q;
	logic [2:0] ana_q;
	logic [3:0] stable_d;

	// Three stages; the value moves only once stages two and three agree
	assign stable_d = (sync2_q & ~(sync2_q ^ sync3_q)) | (stable_q & (sync2_q ^ sync3_q));

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			sync1_q <= `PEM_SYNC_RESET;
			sync2_q <= `PEM_SYNC_RESET;
			sync3_q <= `PEM_SYNC_RESET;
			stable_q <= `PEM_SYNC_RESET;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			stable_q <= stable_d;
		end
	end

	// Config registered; reset leaves every general pin (0..2) an analog input, safe for the pads
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			dir_q <= `PEM_DIR_RESET;
			ana_q <= `PEM_ANA_RESET;
		end else begin
			dir_q <= cfg.direction_control;
			ana_q <= cfg.analog_select;
		end
	end

	// ****************************************************************
	// Function decode per general pin
	// ****************************************************************
	logic [2:0] periph_val;
	logic [2:0] periph_en;
	logic [2:0] dig_in_en;
	logic [2:0] out_d;
	logic [2:0] oe_d;
	logic [2:0] out_q;
	logic [2:0] oe_q;
	logic route_ok;

	// Unit 3 only reaches pin 0 while the route select is clear
	assign route_ok = ~unit3_pin_route_select;
	// PWM A wins over plain compare when both are enabled
	assign periph_en[`PEM_PIN0] = route_ok & (periph.unit3_pwm_a_en | periph.unit3_cmp_en);
	assign periph_val[`PEM_PIN0] = periph.unit3_pwm_a_en ? periph.unit3_pwm_a : periph.unit3_cmp;
	assign periph_en[`PEM_PIN1] = periph.unit3_pwm_b_en;
	assign periph_val[`PEM_PIN1] = periph.unit3_pwm_b;
	assign periph_en[`PEM_PIN2] = periph.unit5_cmp_en;
	assign periph_val[`PEM_PIN2] = periph.unit5_cmp;

	genvar gi;
	generate
		for (gi = 0; gi < `PEM_NUM_GEN_PINS; gi++) begin : g_pin
			// Output driver: direction 0 drives regardless of analog select
			assign oe_d[gi] = (dir_q[gi] == `PEM_DIR_OUT);
			// Peripheral overrides the latch
			assign out_d[gi] = periph_en[gi] ? periph_val[gi] : output_latch[gi];
			// Digital input buffer off whenever analog is selected
			assign dig_in_en[gi] = (dir_q[gi] == `PEM_DIR_IN) & ~ana_q[gi];
			// Analog channel switch
			assign analog_en[gi] = dir_q[gi] & ana_q[gi];
		end
	endgenerate

	// Pin drive comes from flops so the pads see clean levels
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			out_q <= `PEM_DRIVE_RESET;
			oe_q <= `PEM_DRIVE_RESET;
		end else begin
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	assign pin_out = out_q;
	assign pin_oe = oe_q;

	// ****************************************************************
	// Input side and pin 3
	// ****************************************************************
	logic [3:0] in_val_q;
	logic cap3_q;
	logic cap5_q;
	logic clear_pin_q;

	// Disabled inputs read as zero; pin 3 reads zero while it is master clear
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			in_val_q <= `PEM_INPUT_RESET;
			cap3_q <= `PEM_CAP_RESET;
			cap5_q <= `PEM_CAP_RESET;
			clear_pin_q <= `PEM_CLEAR_RESET;
		end else begin
			in_val_q[2:0] <= stable_q[2:0] & dig_in_en;
			in_val_q[`PEM_PIN3] <= stable_q[`PEM_PIN3] & ~external_reset_enable;
			cap3_q <= stable_q[`PEM_PIN0] & dig_in_en[`PEM_PIN0] & route_ok;
			cap5_q <= stable_q[`PEM_PIN2] & dig_in_en[`PEM_PIN2];
			clear_pin_q <= stable_q[`PEM_PIN3] | ~external_reset_enable;
		end
	end

	assign pin_input_value = in_val_q;
	assign unit3_capture_in = cap3_q;
	assign unit5_capture_in = cap5_q;
	assign master_clear_n = clear_pin_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_latch_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && !$past(dir_q[1]) && !$past(periph_en[1])
		|-> pin_oe[1] && pin_out[1] == $past(output_latch[1]))
		else $error("pin 1 latch not driven");
	a_dig_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && $past(ana_q[0]) |-> !pin_input_value[0])
		else $error("digital input not disabled under analog");
	a_cap3_route: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && $past(unit3_pin_route_select) |-> !unit3_capture_in)
		else $error("unit 3 capture while routed away");
	a_cap5_path: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && $past(dig_in_en[2]) |-> unit5_capture_in == $past(stable_q[2]))
		else $error("unit 5 capture mismatch");
	a_pwm_b: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && $past(periph.unit3_pwm_b_en) && !$past(dir_q[1])
		|-> pin_out[1] == $past(periph.unit3_pwm_b))
		else $error("pwm B not on pin 1");
	a_route_latch: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && $past(unit3_pin_route_select) |-> pin_out[0] == $past(output_latch[0]))
		else $error("unit 3 reached pin 0 while routed away");
	a_pin3_input: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && $past(external_reset_enable) |-> !pin_input_value[3])
		else $error("pin 3 read while master clear");
	a_clear_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && $past(external_reset_enable) |-> master_clear_n == $past(stable_q[3]))
		else $error("master clear not following pin 3");
	a_clear_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && !$past(external_reset_enable) |-> master_clear_n)
		else $error("master clear asserted while pin 3 is plain input");
	a_pin3_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && !$past(external_reset_enable)
		|-> pin_input_value[3] == $past(stable_q[3]))
		else $error("pin 3 plain input not read");
	// Analog switch follows the configuration ports, one edge behind
	a_analog_ch: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n)
		|-> analog_en == ($past(cfg.direction_control) & $past(cfg.analog_select)))
		else $error("analog channel decode wrong");
	a_analog_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && $past(analog_en[0]) |-> !pin_input_value[0] && !unit3_capture_in)
		else $error("digital path live on an analog pin");
	// Output side: direction alone gates the driver, latch rules when no peripheral claims
	a_oe_dir: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && $past(reset_n, 2) |-> pin_oe == ~$past(cfg.direction_control, 2))
		else $error("pin driver does not follow direction");
	a_latch_all: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && $past(periph_en) == 3'h0 |-> pin_out == $past(output_latch))
		else $error("latch not on pins");
	a_pwm_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && !$past(unit3_pin_route_select) && $past(periph.unit3_pwm_a_en)
		|-> pin_out[0] == $past(periph.unit3_pwm_a))
		else $error("pwm A not on pin 0");
	a_cmp3_out: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && !$past(unit3_pin_route_select) && $past(periph.unit3_cmp_en)
		&& !$past(periph.unit3_pwm_a_en) |-> pin_out[0] == $past(periph.unit3_cmp))
		else $error("unit 3 compare not on pin 0");
	// Input side: enabled digital paths pass the synchronised level; the last check is unit 5 overriding the pin 2 latch
	a_dig_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && $past(dir_q[1]) && !$past(ana_q[1])
		|-> pin_input_value[1] == $past(stable_q[1]))
		else $error("pin 1 digital input not read");
	a_cap3_path: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && !$past(unit3_pin_route_select) && $past(dig_in_en[0])
		|-> unit3_capture_in == $past(stable_q[0]))
		else $error("unit 3 capture input not passed");
	a_periph_win: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(reset_n) && $past(periph_en[2]) |-> pin_out[2] == $past(periph.unit5_cmp))
		else $error("unit 5 did not override latch");

endmodule : pem_pin_mux

// file: pem_pad_model.sv
// Pad model standing at the port E package pins
`timescale 1ns/10ps

// ****************************************
// Pad model
// ****************************************
module pem_pad_model (
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	input wire logic [3:0] ext_level,
	output logic [3:0] pin_in
);
	// Driven pads read back their own drive, so a contended pad never reads as the outside level
	assign pin_in = {ext_level[3], (pin_oe & pin_out) | (~pin_oe & ext_level[2:0])};
endmodule : pem_pad_model

// file: pem_pin_mux_bench.sv
// Self-checking bench for the port E pin function selector
`timescale 1ns/10ps

// ****************************************
// Bench
// ****************************************
module pem_pin_mux_bench;
	import pem_pkg::*;
	logic clk_sys = 1'h0;
	logic reset_n = 1'h0;
	pem_cfg_t cfg = 6'h3F;
	logic [2:0] output_latch = 3'h0;
	pem_periph_t periph = 8'h00;
	logic route_sel = 1'h0;
	logic rst_en = 1'h0;
	logic [3:0] ext = 4'h0;
	logic [3:0] pin_in;
	logic [2:0] pin_out;
	logic [2:0] pin_oe;
	logic [2:0] analog_en;
	logic [3:0] pin_value;
	logic cap3;
	logic cap5;
	logic clear_n;
	int error_cnt = 0;
	int total_checks = 0;

	pem_pin_mux dut (.clk_sys(clk_sys), .reset_n(reset_n), .cfg(cfg), .output_latch(output_latch),
		.periph(periph), .unit3_pin_route_select(route_sel), .external_reset_enable(rst_en),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_input_value(pin_value),
		.analog_en(analog_en), .unit3_capture_in(cap3), .unit5_capture_in(cap5),
		.master_clear_n(clear_n));
	pem_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

	// Free-running 100 MHz clock
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	// Compare and count
	task chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Apply one setting; eight edges cover driver release, three sync stages and output flop
	task step(input logic [5:0] c, input logic [2:0] lat, input logic [7:0] p, input logic rs,
		input logic re, input logic [3:0] x);
		@(posedge clk_sys);
		cfg <= c;
		output_latch <= lat;
		periph <= p;
		route_sel <= rs;
		rst_en <= re;
		ext <= x;
		repeat (8) @(posedge clk_sys);
		#1;
	endtask : step

	task tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	// Main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		#1;
		chk("oe_reset", 4'(pin_oe), 4'h0);
		chk("analog_reset", 4'(analog_en), 4'h7);
		@(posedge clk_sys);
		reset_n <= 1'h1;
		step(6'h00, 3'h5, 8'h00, 1'h0, 1'h0, 4'h0);
		chk("latch_out", 4'(pin_out), 4'h5);
		chk("latch_oe", 4'(pin_oe), 4'h7);
		step(6'h00, 3'h5, 8'h71, 1'h0, 1'h0, 4'h0);
		chk("pwm_ab_u5", 4'(pin_out), 4'h2);
		step(6'h00, 3'h2, 8'h0C, 1'h0, 1'h0, 4'h0);
		chk("cmp3_out", 4'(pin_out), 4'h3);
		step(6'h00, 3'h0, 8'hC0, 1'h1, 1'h0, 4'h0);
		chk("route_away", 4'(pin_out), 4'h0);
		step(6'h00, 3'h0, 8'hC0, 1'h0, 1'h0, 4'h0);
		chk("route_home", 4'(pin_out), 4'h1);
		// Analog select on an output pin changes nothing; PWM A beats compare
		step(6'h07, 3'h2, 8'hC4, 1'h0, 1'h0, 4'h0);
		chk("ana_out", 4'(pin_out), 4'h3);
		chk("ana_out_oe", 4'(pin_oe), 4'h7);
		chk("ana_out_sw", 4'(analog_en), 4'h0);
		// Digital inputs, pin 3 plain
		step(6'h38, 3'h7, 8'hFF, 1'h0, 1'h0, 4'hD);
		chk("in_oe", 4'(pin_oe), 4'h0);
		chk("in_value", pin_value, 4'hD);
		chk("cap3_in", 4'(cap3), 4'h1);
		chk("cap5_in", 4'(cap5), 4'h1);
		chk("clear_off", 4'(clear_n), 4'h1);
		step(6'h38, 3'h7, 8'h00, 1'h1, 1'h0, 4'hD);
		chk("cap3_away", 4'(cap3), 4'h0);
		// Analog select kills the digital path
		step(6'h3F, 3'h7, 8'h00, 1'h0, 1'h0, 4'h7);
		chk("ana_en", 4'(analog_en), 4'h7);
		chk("ana_value", pin_value, 4'h0);
		chk("ana_caps", {2'h0, cap3, cap5}, 4'h0);
		// Master clear follows pin 3
		step(6'h3F, 3'h0, 8'h00, 1'h0, 1'h1, 4'h0);
		chk("clear_low", 4'(clear_n), 4'h0);
		step(6'h3F, 3'h0, 8'h00, 1'h0, 1'h1, 4'h8);
		chk("clear_high", 4'(clear_n), 4'h1);
		chk("clear_value", pin_value, 4'h0);
		// Mid-run reset drops the drivers and the read path
		step(6'h00, 3'h7, 8'h00, 1'h0, 1'h0, 4'hF);
		chk("drive_pre", 4'(pin_out), 4'h7);
		@(posedge clk_sys);
		reset_n <= 1'h0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("oe_rerun", 4'(pin_oe), 4'h0);
		chk("out_rerun", 4'(pin_out), 4'h0);
		chk("analog_rerun", 4'(analog_en), 4'h7);
		chk("value_rerun", pin_value, 4'h0);
		@(posedge clk_sys);
		reset_n <= 1'h1;
		step(6'h00, 3'h6, 8'h00, 1'h0, 1'h0, 4'hF);
		chk("out_rerelease", 4'(pin_out), 4'h6);
		chk("value_rerelease", pin_value, 4'h8);
		tally_and_finish();
	end
endmodule : pem_pin_mux_bench
